//--- spm_defines.vh
`ifndef SPM_DEFINES_VH
`define SPM_DEFINES_VH

// register offsets on the 8-bit register port
`define SPM_ADDR_FLAGS     8'h28
`define SPM_ADDR_BUFFER    8'h29
`define SPM_ADDR_CONTROL   8'h2a

// serial_control field positions
`define SPM_CTRL_RATE_LO   0
`define SPM_CTRL_RATE_HI   1
`define SPM_CTRL_PHASE     2
`define SPM_CTRL_POLARITY  3
`define SPM_CTRL_MASTER    4
`define SPM_CTRL_ORDER     5
`define SPM_CTRL_ENABLE    6
`define SPM_CTRL_NOFAULT   7

// serial_flags field positions
`define SPM_FLAG_DONE      7
`define SPM_FLAG_COLLIDE   6
`define SPM_FLAG_OVERRUN   5

// reset values
`define SPM_CTRL_RESET     8'h00
`define SPM_BUF_RESET      8'h00

// half serial period minus one, in mclk cycles, per rate code
`define SPM_HALF_DIV4      5'h01
`define SPM_HALF_DIV8      5'h03
`define SPM_HALF_DIV16     5'h07
`define SPM_HALF_DIV64     5'h1f

// sixteen clock edges per byte, counted from zero
`define SPM_LAST_EDGE      4'hf

`endif

//--- spm_serial_port.v
// Local design decision: the strobed register port.
`include "spm_defines.vh"

module spm_serial_port (
    input  wire       mclk,
    input  wire       srst,
    input  wire [7:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata,
    input  wire       sclk_in,
    output wire       sclk_out,
    output wire       sclk_oe,
    input  wire       mosi_in,
    output wire       mosi_out,
    output wire       mosi_oe,
    input  wire       miso_in,
    output wire       miso_out,
    output wire       miso_oe,
    input  wire       ss_n_in,
    output reg        transfer_irq
);

    // bit that leaves the shift register next, by chosen order
    function top_bit;
        input [7:0] data;
        input       lsb_first;
        begin
            top_bit = lsb_first ? data[0] : data[7];
        end
    endfunction

    // half serial period reload, per rate code
    function [4:0] half_period;
        input [1:0] rate;
        begin
            case (rate)
                2'h0:    half_period = `SPM_HALF_DIV4;
                2'h1:    half_period = `SPM_HALF_DIV8;
                2'h2:    half_period = `SPM_HALF_DIV16;
                default: half_period = `SPM_HALF_DIV64;
            endcase
        end
    endfunction

    // a strobe aimed at one register address
    function hits;
        input       strobe;
        input [7:0] addr;
        input [7:0] target;
        begin
            hits = strobe && (addr == target);
        end
    endfunction

    reg  [7:0] ctrl_ff;
    reg  [7:0] shift_ff;
    reg        out_bit_ff;
    reg        xfer_ff;
    reg  [3:0] edge_cnt_ff;
    reg  [4:0] div_ff;
    reg        sclk_lvl_ff;
    reg        sclk_prev_ff;
    reg        done_ff;
    reg        collide_ff;
    reg        overrun_ff;
    reg        clr_arm_ff;
    reg  [3:0] sync1_ff;
    reg  [3:0] sync2_ff;
    reg  [3:0] sync3_ff;
    reg  [3:0] filt_ff;

    wire [3:0] pins_in;
    wire       master;
    wire       enable;
    wire       phase;
    wire       polarity;
    wire       lsb_first;
    wire       sclk_s;
    wire       mosi_s;
    wire       miso_s;
    wire       ss_n_s;
    wire       ctrl_wr;
    wire       data_wr;
    wire       data_rd;
    wire       stat_rd;
    wire       data_acc;
    wire       wr_block;
    wire       wr_ok;
    wire       wr_col;
    wire       start;
    wire       m_edge;
    wire       s_edge;
    wire       any_edge;
    wire       lead;
    wire       sample;
    wire       shift;
    wire       last;
    wire       in_bit;
    wire       flag_clr;
    wire       nxt_done;

    // control fields
    assign master    = ctrl_ff[`SPM_CTRL_MASTER];
    assign enable    = ctrl_ff[`SPM_CTRL_ENABLE];
    assign phase     = ctrl_ff[`SPM_CTRL_PHASE];
    assign polarity  = ctrl_ff[`SPM_CTRL_POLARITY];
    assign lsb_first = ctrl_ff[`SPM_CTRL_ORDER];

    // pin synchronisers: three stages, a change counts once stages two and three agree
    assign pins_in = {ss_n_in, miso_in, mosi_in, sclk_in};

    // pin levels held through reset: select idles high, the rest low
    localparam [3:0] PIN_IDLE = 4'h8;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
            always @(posedge mclk) begin
                if (srst) begin
                    sync1_ff[gi] <= PIN_IDLE[gi];
                    sync2_ff[gi] <= PIN_IDLE[gi];
                    sync3_ff[gi] <= PIN_IDLE[gi];
                    filt_ff[gi]  <= PIN_IDLE[gi];
                end else begin
                    sync1_ff[gi] <= pins_in[gi];
                    sync2_ff[gi] <= sync1_ff[gi];
                    sync3_ff[gi] <= sync2_ff[gi];
                    if (sync2_ff[gi] == sync3_ff[gi]) begin
                        filt_ff[gi] <= sync3_ff[gi];
                    end
                end
            end
        end
    endgenerate

    assign sclk_s = filt_ff[0];
    assign mosi_s = filt_ff[1];
    assign miso_s = filt_ff[2];
    assign ss_n_s = filt_ff[3];

    // register port decode
    assign ctrl_wr  = hits(reg_wr, reg_addr, `SPM_ADDR_CONTROL);
    assign data_wr  = hits(reg_wr, reg_addr, `SPM_ADDR_BUFFER);
    assign data_rd  = hits(reg_rd, reg_addr, `SPM_ADDR_BUFFER);
    assign stat_rd  = hits(reg_rd, reg_addr, `SPM_ADDR_FLAGS);
    assign data_acc = data_wr | data_rd;

    // data writes refused during a transfer, or in a selected phase 0 slave
    assign wr_block = xfer_ff | (~master & ~phase & ~ss_n_s);
    assign wr_ok    = data_wr & ~wr_block;
    assign wr_col   = data_wr & wr_block;
    assign start    = wr_ok & master & enable;

    // serial clock edges: made by the divider as master, seen on the pin as slave
    assign m_edge   = master & xfer_ff & (div_ff == 5'h00);
    assign s_edge   = ~master & enable & ~ss_n_s & (sclk_s != sclk_prev_ff);
    assign any_edge = m_edge | s_edge;
    assign lead     = master ? (sclk_lvl_ff == polarity) : (sclk_s != polarity);
    assign sample   = any_edge & ~(lead ^ ~phase);
    assign shift    = any_edge & (lead ^ ~phase);
    assign last     = any_edge & (edge_cnt_ff == `SPM_LAST_EDGE);
    assign in_bit   = master ? miso_s : mosi_s;

    // flag clearing sequence: status read, then a data access
    assign flag_clr = clr_arm_ff & data_acc;
    assign nxt_done = last | (done_ff & ~flag_clr);

    // control register
    always @(posedge mclk) begin
        if (srst) begin
            ctrl_ff <= `SPM_CTRL_RESET;
        end else if (ctrl_wr) begin
            ctrl_ff <= reg_wdata;
        end
    end

    // transfer sequencing and edge counting
    always @(posedge mclk) begin
        if (srst) begin
            xfer_ff     <= 1'b0;
            edge_cnt_ff <= 4'h0;
        end else if (~enable || (~master && ss_n_s)) begin
            xfer_ff     <= 1'b0;
            edge_cnt_ff <= 4'h0;
        end else if (start) begin
            xfer_ff     <= 1'b1;
            edge_cnt_ff <= 4'h0;
        end else if (any_edge) begin
            xfer_ff     <= ~last;
            edge_cnt_ff <= last ? 4'h0 : edge_cnt_ff + 4'h1;
        end
    end

    // master clock divider and pin level; idle level follows polarity
    always @(posedge mclk) begin
        if (srst) begin
            div_ff      <= 5'h00;
            sclk_lvl_ff <= 1'b0;
            sclk_prev_ff <= 1'b0;
        end else begin
            sclk_prev_ff <= sclk_s;
            if (start || m_edge) begin
                div_ff <= half_period(ctrl_ff[`SPM_CTRL_RATE_HI:`SPM_CTRL_RATE_LO]);
            end else if (div_ff != 5'h00) begin
                div_ff <= div_ff - 5'h01;
            end
            if (m_edge) begin
                sclk_lvl_ff <= ~sclk_lvl_ff;
            end else if (~xfer_ff) begin
                sclk_lvl_ff <= polarity;
            end
        end
    end

    // single shift register: sampled bits push the sent byte out
    always @(posedge mclk) begin
        if (srst) begin
            shift_ff <= `SPM_BUF_RESET;
        end else if (wr_ok) begin
            shift_ff <= reg_wdata;
        end else if (sample) begin
            if (lsb_first) begin
                shift_ff <= {in_bit, shift_ff[7:1]};
            end else begin
                shift_ff <= {shift_ff[6:0], in_bit};
            end
        end
    end

    // outgoing bit: set at write for phase 0, advanced at each shift edge
    always @(posedge mclk) begin
        if (srst) begin
            out_bit_ff <= 1'b0;
        end else if (wr_ok && ~phase) begin
            out_bit_ff <= top_bit(reg_wdata, lsb_first);
        end else if (shift || ~xfer_ff) begin
            out_bit_ff <= top_bit(shift_ff, lsb_first);
        end
    end

    // status flags; a new event wins over a clear in the same cycle
    always @(posedge mclk) begin
        if (srst) begin
            done_ff    <= 1'b0;
            collide_ff <= 1'b0;
        end else begin
            done_ff <= nxt_done;
            if (wr_col) begin
                collide_ff <= 1'b1;
            end else if (flag_clr) begin
                collide_ff <= 1'b0;
            end
        end
    end

    // overrun: slave only, a byte finished while the last one is still unread
    always @(posedge mclk) begin
        if (srst) begin
            overrun_ff <= 1'b0;
        end else if (master) begin
            overrun_ff <= 1'b0;
        end else if (last && done_ff) begin
            overrun_ff <= 1'b1;
        end else if (flag_clr) begin
            overrun_ff <= 1'b0;
        end
    end

    // clear sequence armed by a status read, spent by a data access
    always @(posedge mclk) begin
        if (srst) begin
            clr_arm_ff <= 1'b0;
        end else if (stat_rd) begin
            clr_arm_ff <= 1'b1;
        end else if (data_acc) begin
            clr_arm_ff <= 1'b0;
        end
    end

    // interrupt pulse on the rising done flag
    always @(posedge mclk) begin
        if (srst) begin
            transfer_irq <= 1'b0;
        end else begin
            transfer_irq <= nxt_done & ~done_ff;
        end
    end

    // read data, one cycle after the read strobe; unmapped reads zero
    always @(posedge mclk) begin
        if (srst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `SPM_ADDR_CONTROL: reg_rdata <= ctrl_ff;
                `SPM_ADDR_BUFFER:  reg_rdata <= shift_ff;
                `SPM_ADDR_FLAGS:   reg_rdata <= {done_ff, collide_ff,
                                                 overrun_ff & ~master, 5'h00};
                default:           reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // pin drivers by mode
    assign sclk_out = sclk_lvl_ff;
    assign sclk_oe  = master & enable;
    assign mosi_out = out_bit_ff;
    assign mosi_oe  = master & enable;
    assign miso_out = out_bit_ff;
    assign miso_oe  = ~master & enable;

endmodule // spm_serial_port

//--- spm_serial_port_chk.sv
module spm_serial_port_chk (
    input wire       mclk,
    input wire       srst,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire       reg_wr,
    input wire       reg_rd,
    input wire [7:0] reg_rdata,
    input wire       sclk_out,
    input wire       sclk_oe,
    input wire       mosi_oe,
    input wire       miso_oe,
    input wire       transfer_irq
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] ctl_ff;
    logic [4:0] tog_ff;
    logic [2:0] cwq_ff;
    logic       prv_ff, iq_ff;
    wire        cw = reg_wr && reg_addr == 8'h2a;
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    // control shadow and clock toggles per byte, cleared around format changes
    always @(posedge mclk) begin
        prv_ff <= sclk_out;
        iq_ff  <= transfer_irq;
        cwq_ff <= {cwq_ff[1:0], cw};
        if (srst)
            ctl_ff <= 8'h00;
        else if (cw)
            ctl_ff <= reg_wdata;
        if (srst || cw || cwq_ff != 3'h0 || iq_ff)
            tog_ff <= 5'h00;
        else if (sclk_out != prv_ff)
            tog_ff <= tog_ff + 5'h01;
    end
    a_irq_single: assert property (transfer_irq |=> !transfer_irq)
        else $error("irq wider than one cycle");
    a_clk_count: assert property (transfer_irq && sclk_oe |=> tog_ff == 5'h10)
        else $error("clock edge count wrong");
    a_clk_idle: assert property (transfer_irq && sclk_oe |-> (sclk_out == ctl_ff[3]) [*4])
        else $error("clock not at idle level");
    a_clk_drive: assert property (sclk_oe == (ctl_ff[6] && ctl_ff[4]))
        else $error("clock drive wrong");
    a_data_dirs: assert property (mosi_oe == sclk_oe && !(mosi_oe && miso_oe))
        else $error("data pin direction wrong");
    a_miso_gate: assert property (miso_oe == (ctl_ff[6] && !ctl_ff[4]))
        else $error("miso drive wrong");
    a_ovf_master: assert property (reg_rd && reg_addr == 8'h28 && ctl_ff[4] |=> !reg_rdata[5])
        else $error("overrun set in master");
    a_ctl_back: assert property (reg_rd && reg_addr == 8'h2a |=> reg_rdata == $past(ctl_ff))
        else $error("control readback wrong");
    c_done: cover property (transfer_irq && sclk_oe);
    c_collide: cover property (reg_rd && reg_addr == 8'h28 ##1 reg_rdata[6]);
    c_slave: cover property (miso_oe);
endmodule // spm_serial_port_chk

bind spm_serial_port spm_serial_port_chk u_chk (.mclk, .srst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .sclk_out, .sclk_oe, .mosi_oe, .miso_oe, .transfer_irq);

//--- spm_far_slave.sv
module spm_far_slave (
    input  wire        sclk,
    input  wire        mosi,
    input  wire        sel_n,
    input  wire        pha,
    input  wire        pol,
    input  wire        lsb,
    input  wire  [7:0] tx,
    output logic       miso,
    output logic [7:0] rx
);
    timeunit 1ns;
    timeprecision 1ns;
    logic q;
    int   k;
    wire  e = sclk ^ pol;
    // released line shows the inverse of the last bit
    assign miso = sel_n ? ~q : q;
    task put;
        if (k < 8)
            q = lsb ? tx[k] : tx[7-k];
        k++;
    endtask
    task take;
        rx = lsb ? {mosi, rx[7:1]} : {rx[6:0], mosi};
    endtask
    // phase 0 shows its first bit at select
    always @(negedge sel_n) begin
        k = 0;
        if (!pha)
            put();
    end
    // shift on one edge, sample on the other, same format as the port
    always @(posedge e) if (!sel_n) begin
        if (pha) put(); else take();
    end
    always @(negedge e) if (!sel_n) begin
        if (pha) take(); else put();
    end
endmodule // spm_far_slave

//--- spm_serial_port_bench.sv
module spm_serial_port_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic       mclk, srst, reg_wr, reg_rd, ss_n_in, psel_n, bclk, bmosi;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, cfg, ptx, prx, v;
    wire        sclk_out, sclk_oe, mosi_out, mosi_oe, miso_out, miso_oe, transfer_irq, pmiso;
    int         miscompares, num_checks, irqs, edges;
    // resolved pins: bench acts as far master while the port is slave; idles low and high
    wire        sclk = sclk_oe ? sclk_out : bclk;
    wire        mosi = mosi_oe ? mosi_out : bmosi;
    wire        miso = miso_oe ? miso_out : pmiso;
    spm_serial_port u_dut (.mclk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .sclk_in(sclk), .sclk_out, .sclk_oe, .mosi_in(mosi), .mosi_out, .mosi_oe,
        .miso_in(miso), .miso_out, .miso_oe, .ss_n_in, .transfer_irq);
    spm_far_slave u_far (.sclk, .mosi, .sel_n(psel_n), .pha(cfg[2]), .pol(cfg[3]),
        .lsb(cfg[5]), .tx(ptx), .miso(pmiso), .rx(prx));
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    // pulse and edge counters
    always @(posedge mclk) if (transfer_irq === 1'b1) irqs++;
    always @(posedge sclk_out) edges++;
    task chk(input logic [7:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            miscompares++;
        end
    endtask
    task wr(input logic [7:0] a, d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(posedge mclk);
        v = reg_rdata;
    endtask
    task rdc(input logic [7:0] a, e);
        rd(a);
        chk(v, e);
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task wait_done;
        for (int i = 0; i < 400; i++) begin
            rd(8'h28);
            if (v[7] === 1'b1)
                return;
        end
        miscompares++;
        give_verdict;
    endtask
    // one master byte against the far slave, optionally with a write mid-way
    task run(input logic [7:0] c, tx, pt, input bit mid);
        cfg = c;
        ptx = pt;
        wr(8'h2a, c);
        repeat (3) @(posedge mclk);
        edges = 0;
        irqs = 0;
        psel_n <= 1'b0;
        wr(8'h29, tx);
        if (mid) begin
            repeat (40) @(posedge mclk);
            wr(8'h29, 8'hff);
        end
        wait_done;
        psel_n <= 1'b1;
        chk(v, mid ? 8'hc0 : 8'h80);
        rdc(8'h29, pt);
        chk(prx, tx);
        chk(8'(edges), 8'h08);
        chk(8'(irqs), 8'h01);
        rdc(8'h28, 8'h00);
        $display("byte done, control %h", c);
    endtask
    // one byte as far master of the slave port, phase 1 timing; v collects miso bits
    task sbyte(input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            @(posedge mclk);
            bclk  <= 1'b1;
            bmosi <= b[7-i];
            repeat (8) @(posedge mclk);
            v = {v[6:0], miso};
            bclk <= 1'b0;
            repeat (7) @(posedge mclk);
        end
    endtask
    task t_reset;
        rdc(8'h2a, 8'h00);
        rdc(8'h28, 8'h00);
        rdc(8'h00, 8'h00);
        chk(8'({sclk_oe, mosi_oe, miso_oe}), 8'h00);
        $display("reset test done");
    endtask
    task t_formats;
        run(8'hd2, 8'ha5, 8'h3c, 1'b0);
        run(8'hda, 8'h69, 8'hf0, 1'b0);
        run(8'hd6, 8'h0f, 8'h96, 1'b0);
        run(8'hff, 8'h81, 8'h5e, 1'b0);
    endtask
    task t_collide;
        run(8'hd2, 8'h5a, 8'hc3, 1'b1);
    endtask
    task t_slave;
        wr(8'h2a, 8'h40);
        @(negedge mclk);
        chk(8'(miso_oe), 8'h01);
        @(posedge mclk);
        ss_n_in <= 1'b0;
        repeat (4) @(posedge mclk);
        wr(8'h29, 8'h77);
        rdc(8'h28, 8'h40);
        rdc(8'h29, 8'hc3);
        @(posedge mclk);
        ss_n_in <= 1'b1;
        repeat (4) @(posedge mclk);
        wr(8'h29, 8'h3c);
        rdc(8'h28, 8'h00);
        sbyte(8'h96);
        rdc(8'h29, 8'h3c);
        rdc(8'h28, 8'h00);
        wr(8'h2a, 8'h44);
        @(posedge mclk);
        ss_n_in <= 1'b0;
        repeat (4) @(posedge mclk);
        wr(8'h29, 8'h5a);
        sbyte(8'ha6);
        chk(v, 8'h5a);
        sbyte(8'h3c);
        chk(v, 8'ha6);
        rdc(8'h28, 8'ha0);
        rdc(8'h29, 8'h3c);
        wr(8'h2a, 8'h00);
        @(negedge mclk);
        chk(8'(miso_oe), 8'h00);
        @(posedge mclk);
        ss_n_in <= 1'b1;
        $display("slave test done");
    endtask
    initial begin
        srst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        ss_n_in = 1'b1;
        psel_n = 1'b1;
        bclk = 1'b0;
        bmosi = 1'b1;
        cfg = 8'h00;
        ptx = 8'h00;
        miscompares = 0;
        num_checks = 0;
        repeat (16) @(posedge mclk);
        srst <= 1'b0;
        repeat (4) @(posedge mclk);
        t_reset;
        t_formats;
        t_collide;
        t_slave;
        give_verdict;
    end
endmodule // spm_serial_port_bench
